/* File: verilog/wpr_pkg.sv */
package wpr_pkg;
    localparam int WPR_NWORDS = 28;
    localparam int WPR_IDXW = 5;
    localparam logic [15:0] WPR_ADDR_DATA_HI = 16'h9e35;
    localparam logic [15:0] WPR_ADDR_DATA_LO = 16'h9e36;
    localparam logic [15:0] WPR_ADDR_COMMAND = 16'h9e37;
    localparam logic [15:0] WPR_ADDR_CELL_CAPACITY = 16'ha029;
    localparam logic [15:0] WPR_ADDR_CELL_SENSITIVITY = 16'ha02b;
    localparam logic [15:0] WPR_ADDR_DIVISION_STEP_CODE = 16'ha02c;
    localparam logic [15:0] WPR_ADDR_SYSTEM_TARE = 16'ha02d;
    localparam logic [15:0] WPR_ADDR_SYSTEM_FULL_CAPACITY = 16'ha02f;
    localparam logic [15:0] WPR_ADDR_FILTER_LEVEL = 16'ha08d;
    localparam logic [15:0] WPR_ADDR_STABILITY_LEVEL = 16'ha08e;
    localparam logic [15:0] WPR_ADDR_AUTOZERO_PERCENT = 16'ha08f;
    localparam logic [15:0] WPR_ADDR_ZERO_TRACK_LEVEL = 16'ha091;
    localparam logic [15:0] WPR_ADDR_ZERO_BAND_DIVISIONS = 16'ha092;
    localparam logic [15:0] WPR_ADDR_SETPOINT1_MODE = 16'ha0f1;
    localparam logic [15:0] WPR_ADDR_SETPOINT1_HYSTERESIS = 16'ha0f2;
    localparam logic [15:0] WPR_ADDR_SETPOINT1_TIMER = 16'ha0f4;
    localparam logic [15:0] WPR_ADDR_SETPOINT1_DELAY = 16'ha0f5;
    localparam logic [15:0] WPR_ADDR_SETPOINT2_MODE = 16'ha0f6;
    localparam logic [15:0] WPR_ADDR_SETPOINT2_HYSTERESIS = 16'ha0f7;
    localparam logic [15:0] WPR_ADDR_SETPOINT2_TIMER = 16'ha0f9;
    localparam logic [15:0] WPR_ADDR_SETPOINT2_DELAY = 16'ha0fa;
    localparam logic [15:0] WPR_ADDR_ANALOG_FULL_SCALE = 16'ha1b9;
    localparam logic [15:0] WPR_ADDR_ANALOG_SOURCE_SELECT = 16'ha1bb;
    localparam logic [15:0] WPR_ADDR_ANALOG_SPAN_SELECT = 16'ha1bc;
    // word address of each stored entry; 32-bit values take two entries, high word first
    localparam logic [15:0] WPR_WORD_ADDR [WPR_NWORDS] = '{
        WPR_ADDR_CELL_CAPACITY, WPR_ADDR_CELL_CAPACITY + 16'h0001,
        WPR_ADDR_CELL_SENSITIVITY, WPR_ADDR_DIVISION_STEP_CODE,
        WPR_ADDR_SYSTEM_TARE, WPR_ADDR_SYSTEM_TARE + 16'h0001,
        WPR_ADDR_SYSTEM_FULL_CAPACITY, WPR_ADDR_SYSTEM_FULL_CAPACITY + 16'h0001,
        WPR_ADDR_FILTER_LEVEL, WPR_ADDR_STABILITY_LEVEL,
        WPR_ADDR_AUTOZERO_PERCENT, WPR_ADDR_AUTOZERO_PERCENT + 16'h0001,
        WPR_ADDR_ZERO_TRACK_LEVEL, WPR_ADDR_ZERO_BAND_DIVISIONS,
        WPR_ADDR_SETPOINT1_MODE,
        WPR_ADDR_SETPOINT1_HYSTERESIS, WPR_ADDR_SETPOINT1_HYSTERESIS + 16'h0001,
        WPR_ADDR_SETPOINT1_TIMER, WPR_ADDR_SETPOINT1_DELAY,
        WPR_ADDR_SETPOINT2_MODE,
        WPR_ADDR_SETPOINT2_HYSTERESIS, WPR_ADDR_SETPOINT2_HYSTERESIS + 16'h0001,
        WPR_ADDR_SETPOINT2_TIMER, WPR_ADDR_SETPOINT2_DELAY,
        WPR_ADDR_ANALOG_FULL_SCALE, WPR_ADDR_ANALOG_FULL_SCALE + 16'h0001,
        WPR_ADDR_ANALOG_SOURCE_SELECT, WPR_ADDR_ANALOG_SPAN_SELECT};
    localparam logic [WPR_IDXW-1:0] WPR_IDX_DIVISION = 5'h03;
    localparam logic [WPR_IDXW-1:0] WPR_IDX_SP1_MODE = 5'h0e;
    localparam logic [WPR_IDXW-1:0] WPR_IDX_SP2_MODE = 5'h13;
    localparam logic [WPR_IDXW-1:0] WPR_IDX_AN_SOURCE = 5'h1a;
    localparam logic [WPR_IDXW-1:0] WPR_IDX_AN_SPAN = 5'h1b;
    localparam logic [WPR_IDXW-1:0] WPR_IDX_LAST = 5'h1b;
    localparam logic [15:0] WPR_CMD_CAL_FULL_SCALE = 16'h0011;
    localparam logic [15:0] WPR_CMD_SAVE = 16'h0020;
    localparam logic [15:0] WPR_SP_MODE_MASK = 16'h001f;
    localparam int WPR_SP_SRC_LSB = 0;
    localparam int WPR_SP_NC_BIT = 2;
    localparam int WPR_SP_NEG_BIT = 3;
    localparam int WPR_SP_STABLE_BIT = 4;
    localparam int WPR_NDIV = 15;
    // division step in thousandths of a weight unit
    localparam logic [16:0] WPR_DIV_MILLI [WPR_NDIV] = '{
        17'h00001, 17'h00002, 17'h00005, 17'h0000a, 17'h00014, 17'h00032,
        17'h00064, 17'h000c8, 17'h001f4, 17'h003e8, 17'h007d0, 17'h01388,
        17'h02710, 17'h04e20, 17'h0c350};
    typedef enum logic [1:0] {WPR_SRC_NET, WPR_SRC_GROSS, WPR_SRC_PEAK, WPR_SRC_BAD} wpr_src_type;
    typedef enum logic [2:0] {WPR_SPAN_0_20MA, WPR_SPAN_4_20MA, WPR_SPAN_0_10V, WPR_SPAN_0_5V,
                              WPR_SPAN_BAD} wpr_span_type;
    typedef enum logic {WPR_ST_IDLE, WPR_ST_SAVE} wpr_save_state_type;
    typedef struct packed {
        wpr_src_type source;
        logic contact_nc;
        logic negative;
        logic stable_only;
    } wpr_sp_cfg_type;
    typedef struct packed {
        logic strobe;
        logic [15:0] code;
        logic [31:0] arg;
    } wpr_cmd_type;
    typedef struct packed {
        logic write;
        logic [WPR_IDXW-1:0] index;
        logic [15:0] data;
    } wpr_nvm_type;
endpackage

/* File: verilog/wpr_register_bank.sv */
`timescale 1ns/1ps
`default_nettype none
module wpr_register_bank
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    output logic reg_err,
    input wire logic signed [31:0] net_weight,
    input wire logic signed [31:0] gross_weight,
    input wire logic signed [31:0] peak_weight,
    input wire logic weight_stable,
    output wpr_pkg::wpr_cmd_type cmd_out,
    output wpr_pkg::wpr_nvm_type nvm_out,
    output logic save_busy,
    output logic status_mem_flag,
    output logic [16:0] div_step_milli,
    output wpr_pkg::wpr_sp_cfg_type [1:0] sp_cfg,
    output logic signed [1:0][31:0] sp_weight,
    output logic signed [31:0] analog_weight,
    output wpr_pkg::wpr_span_type analog_span
);
    import wpr_pkg::*;

    typedef struct packed {
        logic [WPR_NWORDS-1:0][15:0] words;
        logic [31:0] data;
        logic mem_flag;
        wpr_save_state_type st;
        logic [WPR_IDXW-1:0] idx;
        wpr_nvm_type nvm;
        wpr_cmd_type cmd;
        logic [15:0] rdata;
        logic rvalid;
        logic err;
        logic [16:0] div_milli;
        wpr_sp_cfg_type [1:0] sp;
        logic [1:0][31:0] sp_w;
        logic [31:0] an_w;
        wpr_span_type span;
        logic busy;
    } wpr_state_type;

    wpr_state_type s_r;
    wpr_state_type s_nxt;
    logic [WPR_NWORDS-1:0] hit;
    logic [WPR_IDXW-1:0] hit_idx;
    logic any_hit;

    // one comparator per stored word
    genvar g;
    generate
        for (g = 0; g < WPR_NWORDS; g++)
        begin : g_dec
            assign hit[g] = (reg_addr == WPR_WORD_ADDR[g]);
        end
    endgenerate

    always_comb
    begin
        hit_idx = '0;
        for (int i = 0; i < WPR_NWORDS; i++)
        begin
            if (hit[i])
            begin
                hit_idx = WPR_IDXW'(i);
            end
        end
    end

    assign any_hit = |hit;

    function automatic logic [31:0] pick_weight(input wpr_src_type src);
        logic [31:0] w;
        w = '0;
        case (src)
            WPR_SRC_NET: w = net_weight;
            WPR_SRC_GROSS: w = gross_weight;
            WPR_SRC_PEAK: w = peak_weight;
            default: w = '0;
        endcase
        return w;
    endfunction

    function automatic wpr_sp_cfg_type decode_sp(input logic [15:0] m);
        wpr_sp_cfg_type c;
        c.source = wpr_src_type'(m[WPR_SP_SRC_LSB +: 2]);
        c.contact_nc = m[WPR_SP_NC_BIT];
        c.negative = m[WPR_SP_NEG_BIT];
        c.stable_only = m[WPR_SP_STABLE_BIT];
        return c;
    endfunction

    always_comb
    begin
        logic set_flag;
        logic [15:0] wval;
        logic [15:0] dcode;
        logic [15:0] span_code;
        logic [31:0] w;
        s_nxt = s_r;
        set_flag = 1'b0;
        wval = reg_wdata;
        dcode = '0;
        span_code = '0;
        w = '0;
        s_nxt.cmd.strobe = 1'b0;
        s_nxt.nvm.write = 1'b0;
        s_nxt.rvalid = 1'b0;
        s_nxt.err = 1'b0;

        if (reg_wr_en)
        begin
            if (any_hit)
            begin
                if (hit_idx == WPR_IDX_SP1_MODE || hit_idx == WPR_IDX_SP2_MODE)
                begin
                    wval = reg_wdata & WPR_SP_MODE_MASK;
                end
                s_nxt.words[hit_idx] = wval;
                set_flag = 1'b1;
            end
            else if (reg_addr == WPR_ADDR_DATA_HI)
            begin
                s_nxt.data[31:16] = reg_wdata;
            end
            else if (reg_addr == WPR_ADDR_DATA_LO)
            begin
                s_nxt.data[15:0] = reg_wdata;
            end
            else if (reg_addr == WPR_ADDR_COMMAND)
            begin
                if (reg_wdata == WPR_CMD_SAVE)
                begin
                    // a save already running simply carries on from where it is
                    if (s_r.st == WPR_ST_IDLE)
                    begin
                        s_nxt.st = WPR_ST_SAVE;
                        s_nxt.idx = '0;
                    end
                end
                else
                begin
                    // argument is whatever the data register holds now, e.g. sample weight
                    s_nxt.cmd.strobe = 1'b1;
                    s_nxt.cmd.code = reg_wdata;
                    s_nxt.cmd.arg = s_r.data;
                end
            end
            else
            begin
                s_nxt.err = 1'b1;
            end
        end

        if (reg_rd_en)
        begin
            s_nxt.rvalid = 1'b1;
            // data and command registers are write-only and read as zero
            s_nxt.rdata = any_hit ? s_r.words[hit_idx] : '0;
            s_nxt.err = !any_hit;
        end

        case (s_r.st)
            WPR_ST_IDLE:
            begin
                s_nxt.idx = s_nxt.idx;
            end
            WPR_ST_SAVE:
            begin
                s_nxt.nvm.write = 1'b1;
                s_nxt.nvm.index = s_r.idx;
                s_nxt.nvm.data = s_r.words[s_r.idx];
                if (s_r.idx == WPR_IDX_LAST)
                begin
                    s_nxt.st = WPR_ST_IDLE;
                    s_nxt.idx = '0;
                    s_nxt.mem_flag = 1'b0;
                end
                else
                begin
                    s_nxt.idx = s_r.idx + 5'h01;
                end
            end
            default:
            begin
                s_nxt.st = WPR_ST_IDLE;
            end
        endcase

        // a write in the finishing cycle keeps the flag up
        if (set_flag)
        begin
            s_nxt.mem_flag = 1'b1;
        end
        // busy is its own flop so the port carries no decode logic
        s_nxt.busy = (s_nxt.st == WPR_ST_SAVE);

        dcode = s_r.words[WPR_IDX_DIVISION];
        s_nxt.div_milli = (dcode < 16'(WPR_NDIV)) ? WPR_DIV_MILLI[dcode[3:0]] : '0;

        for (int k = 0; k < 2; k++)
        begin
            s_nxt.sp[k] = decode_sp(k == 0 ? s_r.words[WPR_IDX_SP1_MODE]
                                           : s_r.words[WPR_IDX_SP2_MODE]);
            w = pick_weight(s_r.sp[k].source);
            if (s_r.sp[k].negative)
            begin
                w = -w;
            end
            // a stable-only setpoint freezes its compared value while weight moves
            if (!s_r.sp[k].stable_only || weight_stable)
            begin
                s_nxt.sp_w[k] = w;
            end
        end

        s_nxt.an_w = pick_weight(wpr_src_type'(s_r.words[WPR_IDX_AN_SOURCE][1:0]));
        if (s_r.words[WPR_IDX_AN_SOURCE] > 16'h0002)
        begin
            s_nxt.an_w = '0;
        end
        span_code = s_r.words[WPR_IDX_AN_SPAN];
        case (span_code)
            16'h0000: s_nxt.span = WPR_SPAN_0_20MA;
            16'h0001: s_nxt.span = WPR_SPAN_4_20MA;
            16'h0002: s_nxt.span = WPR_SPAN_0_10V;
            16'h0003: s_nxt.span = WPR_SPAN_0_5V;
            default: s_nxt.span = WPR_SPAN_BAD;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign reg_rdata = s_r.rdata;
    assign reg_rvalid = s_r.rvalid;
    assign reg_err = s_r.err;
    assign cmd_out = s_r.cmd;
    assign nvm_out = s_r.nvm;
    assign save_busy = s_r.busy;
    assign status_mem_flag = s_r.mem_flag;
    assign div_step_milli = s_r.div_milli;
    assign sp_cfg = s_r.sp;
    assign sp_weight = s_r.sp_w;
    assign analog_weight = s_r.an_w;
    assign analog_span = s_r.span;
endmodule
`default_nettype wire

/* File: tb/wpr_register_bank_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module wpr_register_bank_checker
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire wpr_pkg::wpr_cmd_type cmd_out,
    input wire wpr_pkg::wpr_nvm_type nvm_out,
    input wire logic save_busy,
    input wire logic status_mem_flag,
    input wire logic [16:0] div_step_milli,
    input wire wpr_pkg::wpr_span_type analog_span
);
    import wpr_pkg::*;
    logic [5:0] wcnt_r;
    logic [5:0] wcnt_nxt;
    logic wr_cmd;
    logic wr_div;
    logic wr_span;
    assign wr_cmd = reg_wr_en && reg_addr == WPR_ADDR_COMMAND;
    assign wr_div = reg_wr_en && reg_addr == WPR_ADDR_DIVISION_STEP_CODE;
    assign wr_span = reg_wr_en && reg_addr == WPR_ADDR_ANALOG_SPAN_SELECT;
    // counts image words of the current save so the order can be tied to the count
    always_comb
    begin
        wcnt_nxt = wcnt_r;
        if (wr_cmd && reg_wdata == WPR_CMD_SAVE && !save_busy)
        begin
            wcnt_nxt = 6'h00;
        end
        else if (nvm_out.write)
        begin
            wcnt_nxt = wcnt_r + 6'h01;
        end
    end
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            wcnt_r <= 6'h00;
        end
        else
        begin
            wcnt_r <= wcnt_nxt;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    AST_DIV_TOP: assert property (
        (wr_div && reg_wdata == 16'h000e) ##1 !wr_div |=> div_step_milli == 17'h0c350)
        else $error("division step wrong after top code");
    AST_FLAG_SET: assert property (
        reg_wr_en && reg_addr == WPR_ADDR_FILTER_LEVEL |=> status_mem_flag)
        else $error("memory flag not set after saved word write");
    AST_SAVE_START: assert property (
        wr_cmd && reg_wdata == WPR_CMD_SAVE && !save_busy |=> save_busy)
        else $error("save did not start");
    AST_NVM_ORDER: assert property (
        nvm_out.write |-> nvm_out.index == wcnt_r[4:0] && wcnt_r < 6'h1c)
        else $error("image word out of order or too many");
    AST_CAL_STROBE: assert property (
        wr_cmd && reg_wdata == WPR_CMD_CAL_FULL_SCALE
        |=> cmd_out.strobe && cmd_out.code == WPR_CMD_CAL_FULL_SCALE)
        else $error("calibration command not issued");
    AST_SAVE_NO_STROBE: assert property (
        wr_cmd && reg_wdata == WPR_CMD_SAVE |=> !cmd_out.strobe)
        else $error("save command leaked to command output");
    AST_SPAN: assert property (
        (wr_span && reg_wdata == 16'h0002) ##1 !wr_span |=> analog_span == WPR_SPAN_0_10V)
        else $error("span code 2 not decoded");
    AST_WO_READ: assert property (
        reg_rd_en && (reg_addr == WPR_ADDR_DATA_HI || reg_addr == WPR_ADDR_DATA_LO)
        |=> reg_rvalid && reg_rdata == 16'h0000)
        else $error("write-only data word readable");
    AST_SP_MASK: assert property (
        reg_rd_en && reg_addr == WPR_ADDR_SETPOINT1_MODE |=> reg_rdata[15:5] == 11'h000)
        else $error("setpoint mode upper bits not zero");
    cover property (wr_cmd && reg_wdata == WPR_CMD_SAVE ##1 save_busy);
    cover property (cmd_out.strobe);
    cover property (nvm_out.write && nvm_out.index == 5'h1b);
endmodule
bind wpr_register_bank wpr_register_bank_checker chk (.core_clk, .sys_rst, .reg_wr_en,
    .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .cmd_out, .nvm_out,
    .save_busy, .status_mem_flag, .div_step_milli, .analog_span);
`default_nettype wire

/* File: tb/wpr_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
module wpr_master_model
(
    input wire logic core_clk,
    output logic reg_wr_en,
    output logic reg_rd_en,
    output logic [15:0] reg_addr,
    output logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic reg_err
);
    import wpr_pkg::*;
    initial
    begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 16'h0000;
        reg_wdata = 16'h0000;
    end
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        reg_wr_en <= 1'b1;
        reg_rd_en <= 1'b0;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
    endtask
    // released lines show the inverse so stale values cannot pass for answers
    task automatic idle();
        reg_wr_en <= 1'b0;
        reg_rd_en <= 1'b0;
        reg_addr <= ~reg_addr;
        reg_wdata <= ~reg_wdata;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic v, output logic e);
        reg_rd_en <= 1'b1;
        reg_wr_en <= 1'b0;
        reg_addr <= a;
        @(posedge core_clk);
        idle();
        d = reg_rdata;
        v = reg_rvalid;
        e = reg_err;
    endtask
    // one burst: argument first, high word at the lower number, command last
    task automatic cal(input logic [31:0] arg, input logic [15:0] code);
        wr(WPR_ADDR_DATA_HI, arg[31:16]);
        wr(WPR_ADDR_DATA_LO, arg[15:0]);
        wr(WPR_ADDR_COMMAND, code);
        idle();
    endtask
endmodule
`default_nettype wire

/* File: tb/wpr_register_bank_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module wpr_register_bank_tb;
    import wpr_pkg::*;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic weight_stable = 1'b1;
    logic reg_wr_en, reg_rd_en, reg_rvalid, reg_err, save_busy, status_mem_flag, v, e;
    logic [15:0] reg_addr, reg_wdata, reg_rdata, rdat;
    logic signed [31:0] net_weight = 32'h00000064;
    logic signed [31:0] gross_weight = 32'h000000c8;
    logic signed [31:0] peak_weight = 32'h0000012c;
    logic [16:0] div_step_milli;
    wpr_cmd_type cmd_out;
    wpr_nvm_type nvm_out;
    wpr_sp_cfg_type [1:0] sp_cfg;
    logic signed [1:0][31:0] sp_weight;
    logic signed [31:0] analog_weight;
    wpr_span_type analog_span;
    int err_count = 0;
    int comparisons = 0;
    always #5 core_clk = ~core_clk;
    wpr_master_model m (.core_clk(core_clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .reg_err(reg_err));
    wpr_register_bank dut (.core_clk(core_clk), .sys_rst(sys_rst), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_err(reg_err),
        .net_weight(net_weight), .gross_weight(gross_weight), .peak_weight(peak_weight),
        .weight_stable(weight_stable), .cmd_out(cmd_out), .nvm_out(nvm_out),
        .save_busy(save_busy), .status_mem_flag(status_mem_flag),
        .div_step_milli(div_step_milli), .sp_cfg(sp_cfg), .sp_weight(sp_weight),
        .analog_weight(analog_weight), .analog_span(analog_span));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // decoded outputs trail the write by a short pipeline
    task automatic put(input logic [15:0] a, input logic [15:0] d);
        m.wr(a, d);
        repeat (4) m.idle();
    endtask
    task automatic t_div();
        logic [31:0] x;
        for (int c = 0; c < 16; c++)
        begin
            x = (c % 3 == 0 ? 32'h1 : c % 3 == 1 ? 32'h2 : 32'h5) * (32'ha ** (c / 3));
            put(WPR_ADDR_DIVISION_STEP_CODE, 16'(c));
            check("division step", 32'(div_step_milli), c == 15 ? 32'h0 : x);
        end
        $display("test division done");
    endtask
    task automatic t_sp();
        logic [31:0] w [3];
        logic [15:0] md;
        w = '{net_weight, gross_weight, peak_weight};
        for (int s = 0; s < 3; s++)
        begin
            md = 16'hffe0 | 16'(s) | (s == 1 ? 16'h000c : 16'h0000);
            put(WPR_ADDR_SETPOINT1_MODE, md);
            check("sp source", 32'(sp_cfg[0].source), 32'(s));
            check("sp contact", 32'(sp_cfg[0].contact_nc), 32'(s == 1));
            check("sp sign", 32'(sp_cfg[0].negative), 32'(s == 1));
            check("sp weight", sp_weight[0], s == 1 ? -gross_weight : w[s]);
            m.rd(WPR_ADDR_SETPOINT1_MODE, rdat, v, e);
            check("sp readback", 32'(rdat), 32'(md & 16'h001f));
        end
        put(WPR_ADDR_SETPOINT1_MODE, 16'h0010);
        weight_stable <= 1'b0;
        net_weight <= 32'h00000200;
        repeat (4) m.idle();
        check("sp frozen", sp_weight[0], 32'h00000064);
        weight_stable <= 1'b1;
        repeat (4) m.idle();
        check("sp stable", sp_weight[0], 32'h00000200);
        put(WPR_ADDR_SETPOINT2_MODE, 16'h0002);
        check("sp2 weight", sp_weight[1], peak_weight);
        $display("test setpoint done");
    endtask
    task automatic t_an();
        for (int s = 0; s < 4; s++)
        begin
            put(WPR_ADDR_ANALOG_SOURCE_SELECT, 16'(s));
            check("analog weight", analog_weight,
                s == 0 ? net_weight : s == 1 ? gross_weight : s == 2 ? peak_weight : 0);
        end
        for (int r = 0; r < 5; r++)
        begin
            put(WPR_ADDR_ANALOG_SPAN_SELECT, 16'(r));
            check("analog span", 32'(analog_span), 32'(r));
        end
        $display("test analog done");
    endtask
    task automatic t_cal();
        m.cal(32'h000007d0, WPR_CMD_CAL_FULL_SCALE);
        check("cmd strobe", 32'(cmd_out.strobe), 32'h1);
        check("cmd code", 32'(cmd_out.code), 32'h11);
        check("cmd arg", cmd_out.arg, 32'h000007d0);
        m.idle();
        check("cmd pulse", 32'(cmd_out.strobe), 32'h0);
        m.cal(32'h12345678, 16'h0003);
        check("cmd arg order", cmd_out.arg, 32'h12345678);
        m.rd(WPR_ADDR_DATA_LO, rdat, v, e);
        check("write-only read", {15'h0, v, rdat}, 32'h00010000);
        m.rd(16'h0000, rdat, v, e);
        check("unmapped read", {15'h0, e, rdat}, 32'h00010000);
        m.wr(16'h0000, 16'h00ff);
        m.idle();
        check("unmapped write", 32'(reg_err), 32'h1);
        $display("test command done");
    endtask
    task automatic t_save();
        int n;
        n = 0;
        m.wr(WPR_ADDR_CELL_CAPACITY, 16'h1234);
        m.wr(WPR_ADDR_CELL_CAPACITY + 16'h0001, 16'h5678);
        put(WPR_ADDR_FILTER_LEVEL, 16'h0005);
        check("memory flag set", 32'(status_mem_flag), 32'h1);
        m.wr(WPR_ADDR_COMMAND, WPR_CMD_SAVE);
        for (int c = 0; c < 40; c++)
        begin
            if (c == 6)
                m.wr(WPR_ADDR_COMMAND, WPR_CMD_SAVE);
            else
                m.idle();
            if (nvm_out.write === 1'b1)
            begin
                check("nvm index", 32'(nvm_out.index), 32'(n));
                if (n == 0)
                    check("nvm hi", 32'(nvm_out.data), 32'h1234);
                if (n == 8)
                    check("nvm filter", 32'(nvm_out.data), 32'h0005);
                n++;
            end
        end
        check("nvm count", 32'(n), 32'h1c);
        check("save busy", 32'(save_busy), 32'h0);
        check("memory flag clear", 32'(status_mem_flag), 32'h0);
        $display("test save done");
    endtask
    initial
    begin
        #10000;
        err_count++;
        end_sim();
    end
    initial
    begin
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_div();
        t_sp();
        t_an();
        t_cal();
        t_save();
        end_sim();
    end
endmodule
`default_nettype wire
